//--- ttl_pkg.sv
package ttl_pkg;
    // sensor population and reading width
    localparam int NUM_SENSORS = 5;
    localparam int TEMP_W = 8;
    localparam int SEL_W = 3;
    // reading that always stands for the maximum junction temperature
    localparam logic [7:0] TJMAX_CODE = 8'h7f;
    // one count of the reading is one degree
    localparam int DEG_PER_COUNT = 1;
    // programmable trip point indices
    localparam int NUM_TRIPS = 4;
    localparam int TRIP_GEN_ZERO = 0;
    localparam int TRIP_GEN_ONE = 1;
    localparam int TRIP_GEN_TWO = 2;
    localparam int TRIP_HOT = 3;
    // status bit positions: the four trip points, then core hot, then platform hot
    localparam int EVT_CORE_HOT = 4;
    localparam int EVT_PLAT_HOT = 5;
    localparam int NUM_EVENTS = 6;
    // throttling schemes that an event may request
    localparam int NUM_SCHEMES = 2;
    // reset value of the general trip thresholds
    localparam logic [7:0] GEN_THRESH_RST = 8'h00;
    // sensor power-up sequencing
    typedef enum logic [0:0] {TTL_SENS_OFF, TTL_SENS_ON} ttl_sens_state_t;
endpackage

//--- ttl_thermal_trip.sv
// Behaviour
// - sensor trips catastrophically when reading reaches or passes fused limit
// - catastrophic trip stays inactive while its enable is low
// - sensors enabled only after high_freq_pll lock; no trip before that
// - each sensor trip is registered before it reaches shutdown logic
// - catastrophic trip latches until power-cycle reset, no software clear
// - registered trips of all sensors ORed into catastrophic_shutdown
// - hot trip threshold resets from fuses, software may overwrite it
// - general trip points give no event until individually enabled
// - general trip thresholds reset to zero
// - platform hot input starts throttling scheme one or two if enabled
// - core hot and hot trip point reported separately to firmware
// - every non-catastrophic event captured in status, tied to throttle actions
// - reading 127 is Tj max; each count higher is one degree cooler
// - four writable trip settings: hot point plus three general points
`timescale 1ns/100ps
module ttl_thermal_trip #(
    parameter int NUM_SENSORS = ttl_pkg::NUM_SENSORS,
    parameter int TEMP_W = ttl_pkg::TEMP_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic high_freq_pll_lock,
    input wire logic [NUM_SENSORS*TEMP_W-1:0] sensor_reading,
    input wire logic [NUM_SENSORS-1:0] sensor_group_mask,
    input wire logic sensor_group_en,
    input wire logic [ttl_pkg::SEL_W-1:0] sensor_select,
    input wire logic cat_trip_en,
    input wire logic [TEMP_W-1:0] fuse_cat_limit,
    input wire logic [TEMP_W-1:0] fuse_hot_thresh,
    input wire logic [ttl_pkg::NUM_TRIPS-1:0] thresh_wr,
    input wire logic [TEMP_W-1:0] thresh_wdata,
    input wire logic [ttl_pkg::NUM_TRIPS-1:0] trip_en,
    input wire logic core_hot_trip,
    input wire logic platform_hot_input_n,
    input wire logic [ttl_pkg::NUM_EVENTS-1:0] status_clr,
    input wire logic [ttl_pkg::NUM_EVENTS*ttl_pkg::NUM_SCHEMES-1:0] action_map,
    input wire logic [ttl_pkg::NUM_SCHEMES-1:0] scheme_en,
    output logic sensors_enabled,
    output logic [NUM_SENSORS-1:0] sensor_cat_trip,
    output logic catastrophic_shutdown,
    output logic [ttl_pkg::NUM_TRIPS*TEMP_W-1:0] trip_thresh,
    output logic [ttl_pkg::NUM_EVENTS-1:0] trip_status,
    output logic hot_trip_report,
    output logic core_hot_report,
    output logic [ttl_pkg::NUM_SCHEMES-1:0] throttle_req,
    output logic [TEMP_W-1:0] below_tjmax_deg
);
    localparam int NT = ttl_pkg::NUM_TRIPS;
    localparam int NE = ttl_pkg::NUM_EVENTS;
    localparam int NS = ttl_pkg::NUM_SCHEMES;

    ttl_pkg::ttl_sens_state_t sens_state_q, sens_state_d;
    logic [NUM_SENSORS-1:0] cat_q, cat_d;
    logic shut_q, shut_d;
    logic [TEMP_W-1:0] thresh_q [NT];
    logic [TEMP_W-1:0] thresh_d [NT];
    logic [NE-1:0] stat_q, stat_d;
    logic [NS-1:0] thr_q, thr_d;
    logic [TEMP_W-1:0] marg_q, marg_d;
    logic [TEMP_W-1:0] watch_count;
    logic [NE-1:0] evt_now;
    logic sens_on;

    // reading of one sensor out of the flat vector
    function automatic logic [TEMP_W-1:0] reading_of(
        input logic [NUM_SENSORS*TEMP_W-1:0] vec,
        input int idx
    );
        reading_of = vec[idx*TEMP_W +: TEMP_W];
    endfunction

    // hotter is the lower count, so reaching a limit means count <= limit
    function automatic logic at_or_hotter(
        input logic [TEMP_W-1:0] count,
        input logic [TEMP_W-1:0] limit
    );
        at_or_hotter = (count <= limit);
    endfunction

    assign sens_on = (sens_state_q == ttl_pkg::TTL_SENS_ON);

    // sensor enable waits for pll lock; once on it stays on until power cycle
    always_comb begin
        sens_state_d = sens_state_q;
        unique case (sens_state_q)
            ttl_pkg::TTL_SENS_OFF: begin
                if (high_freq_pll_lock) begin
                    sens_state_d = ttl_pkg::TTL_SENS_ON;
                end
            end
            ttl_pkg::TTL_SENS_ON: begin
                sens_state_d = ttl_pkg::TTL_SENS_ON;
            end
        endcase
    end

    // per-sensor catastrophic compare, flopped and sticky
    generate
        for (genvar s = 0; s < NUM_SENSORS; s++) begin : g_cat
            always_comb begin
                cat_d[s] = cat_q[s];
                if (sens_on && cat_trip_en &&
                    at_or_hotter(reading_of(sensor_reading, s), fuse_cat_limit)) begin
                    cat_d[s] = 1'b1;
                end
            end
        end
    endgenerate

    // shutdown looks only at registered trips, so a compare glitch cannot kill rails
    assign shut_d = |cat_q;

    // reading watched by the trip points: hottest enabled sensor or one chosen
    always_comb begin
        watch_count = reading_of(sensor_reading, 0);
        if (sensor_group_en) begin
            watch_count = {TEMP_W{1'b1}};
            for (int s = 0; s < NUM_SENSORS; s++) begin
                if (sensor_group_mask[s] &&
                    reading_of(sensor_reading, s) < watch_count) begin
                    watch_count = reading_of(sensor_reading, s);
                end
            end
        end else if (int'(sensor_select) < NUM_SENSORS) begin
            watch_count = reading_of(sensor_reading, int'(sensor_select));
        end
    end

    // degrees below tj max; a reading hotter than tj max reads as zero
    always_comb begin
        marg_d = '0;
        if (watch_count > ttl_pkg::TJMAX_CODE) begin
            marg_d = TEMP_W'((watch_count - ttl_pkg::TJMAX_CODE) * ttl_pkg::DEG_PER_COUNT);
        end
    end

    // threshold writes; no interlock against a zero general threshold
    always_comb begin
        for (int t = 0; t < NT; t++) begin
            thresh_d[t] = thresh_q[t];
            if (thresh_wr[t]) begin
                thresh_d[t] = thresh_wdata;
            end
        end
    end

    // live events: trip points gated by their enable, plus the two hot inputs
    always_comb begin
        evt_now = '0;
        for (int t = 0; t < NT; t++) begin
            evt_now[t] = sens_on && trip_en[t] &&
                at_or_hotter(watch_count, thresh_q[t]);
        end
        evt_now[ttl_pkg::EVT_CORE_HOT] = core_hot_trip;
        evt_now[ttl_pkg::EVT_PLAT_HOT] = !platform_hot_input_n;
    end

    // sticky status; a new event beats a clear in the same cycle
    assign stat_d = (stat_q & ~status_clr) | evt_now;

    // each status bit requests the schemes its action map selects
    always_comb begin
        thr_d = '0;
        for (int k = 0; k < NS; k++) begin
            for (int e = 0; e < NE; e++) begin
                if (stat_q[e] && action_map[e*NS + k]) begin
                    thr_d[k] = 1'b1;
                end
            end
            if (!platform_hot_input_n) begin
                thr_d[k] = 1'b1;
            end
            thr_d[k] = thr_d[k] && scheme_en[k];
        end
    end

    // one synchronous power-cycle reset clears everything, the trip latch included, except the hot threshold, which loads from fuses
    always_ff @(posedge mclk) begin
        if (rst) begin
            sens_state_q <= ttl_pkg::TTL_SENS_OFF;
            cat_q <= '0;
            shut_q <= 1'b0;
            stat_q <= '0;
            thr_q <= '0;
            marg_q <= '0;
            for (int t = 0; t < NT; t++) begin
                thresh_q[t] <= ttl_pkg::GEN_THRESH_RST;
            end
            thresh_q[ttl_pkg::TRIP_HOT] <= fuse_hot_thresh;
        end else if (clk_en) begin
            sens_state_q <= sens_state_d;
            cat_q <= cat_d;
            shut_q <= shut_d;
            stat_q <= stat_d;
            thr_q <= thr_d;
            marg_q <= marg_d;
            for (int t = 0; t < NT; t++) begin
                thresh_q[t] <= thresh_d[t];
            end
        end
    end

    // outputs straight from flops
    assign sensors_enabled = sens_on;
    assign sensor_cat_trip = cat_q;
    assign catastrophic_shutdown = shut_q;
    assign trip_status = stat_q;
    assign hot_trip_report = stat_q[ttl_pkg::TRIP_HOT];
    assign core_hot_report = stat_q[ttl_pkg::EVT_CORE_HOT];
    assign throttle_req = thr_q;
    assign below_tjmax_deg = marg_q;
    generate
        for (genvar t = 0; t < NT; t++) begin : g_thr_out
            assign trip_thresh[t*TEMP_W +: TEMP_W] = thresh_q[t];
        end
    endgenerate

    // checks
    chk_cat_latch_holds: assert property (@(posedge mclk) disable iff (rst)
        cat_q[0] |=> cat_q[0])
        else $error("catastrophic trip dropped without power cycle");

    chk_cat_before_lock: assert property (@(posedge mclk) disable iff (rst)
        !sens_on |-> (cat_q == '0) && !shut_q)
        else $error("catastrophic trip before sensors enabled");

    chk_cat_disabled: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && !cat_trip_en && cat_q == '0) |=> cat_q == '0)
        else $error("catastrophic trip set while disabled");

    chk_cat_sets: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && sens_on && cat_trip_en &&
         reading_of(sensor_reading, 0) <= fuse_cat_limit) |=> cat_q[0])
        else $error("sensor at limit did not trip");

    chk_shutdown_follow: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && $rose(cat_q[NUM_SENSORS-1])) |=> shut_q)
        else $error("shutdown did not follow registered trip");

    chk_gen_thresh_rst: assert property (@(posedge mclk)
        ($past(rst) && !rst) |-> thresh_q[ttl_pkg::TRIP_GEN_ZERO] == '0 &&
        thresh_q[ttl_pkg::TRIP_GEN_TWO] == '0)
        else $error("general threshold not zero after reset");

    chk_hot_thresh_rst: assert property (@(posedge mclk)
        rst |=> thresh_q[ttl_pkg::TRIP_HOT] == $past(fuse_hot_thresh))
        else $error("hot threshold not loaded from fuses");

    chk_gen_trip_gate: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && !trip_en[ttl_pkg::TRIP_GEN_ONE] &&
         !stat_q[ttl_pkg::TRIP_GEN_ONE] && !status_clr[ttl_pkg::TRIP_GEN_ONE])
        |=> !stat_q[ttl_pkg::TRIP_GEN_ONE])
        else $error("disabled general trip raised status");

    chk_status_sticky: assert property (@(posedge mclk) disable iff (rst)
        (stat_q[ttl_pkg::TRIP_HOT] && !status_clr[ttl_pkg::TRIP_HOT])
        |=> stat_q[ttl_pkg::TRIP_HOT])
        else $error("trip status cleared without software");

    chk_plat_throttle: assert property (@(posedge mclk) disable iff (rst)
        clk_en |-> ##1 (thr_q[0] == $past(!platform_hot_input_n && scheme_en[0]) ||
        $past(stat_q != '0)))
        else $error("platform hot did not drive scheme one");

    // shutdown must be the flopped image of the latched trips, never the raw compare
    chk_shutdown_registered: assert property (@(posedge mclk) disable iff (rst)
        clk_en
        |=> shut_q == ($past(cat_q) != '0))
        else $error("shutdown not taken from registered trips");

    // trip points stay quiet while sensors are still off
    chk_trip_before_lock: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && !sens_on && !stat_q[ttl_pkg::TRIP_GEN_ZERO])
        |=> !stat_q[ttl_pkg::TRIP_GEN_ZERO])
        else $error("trip point event before sensors enabled");

    chk_hot_report: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && evt_now[ttl_pkg::TRIP_HOT])
        |=> hot_trip_report)
        else $error("hot trip point not reported");

    chk_core_report: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && core_hot_trip)
        |=> core_hot_report)
        else $error("core hot not reported");

    chk_plat_status: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && !platform_hot_input_n)
        |=> stat_q[ttl_pkg::EVT_PLAT_HOT])
        else $error("platform hot not captured in status");

    // a disabled scheme never reaches the throttle outputs
    chk_throttle_gate: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && !scheme_en[1])
        |=> !thr_q[1])
        else $error("disabled scheme requested");

    // grouping may only pick a reading at least as hot as each included sensor
    chk_group_hottest: assert property (@(posedge mclk) disable iff (rst)
        (sensor_group_en && sensor_group_mask[0])
        |-> watch_count <= reading_of(sensor_reading, 0))
        else $error("grouping missed a hotter sensor");

    chk_margin_hot: assert property (@(posedge mclk) disable iff (rst)
        (clk_en && watch_count <= ttl_pkg::TJMAX_CODE)
        |=> marg_q == '0)
        else $error("margin nonzero at or above tj max");
endmodule

//--- ttl_platform_model.sv
`timescale 1ns/100ps
// platform side that pulls the shared hot alert low
module ttl_platform_model (
    input wire logic mclk,
    output logic platform_hot_input_n
);
    // idle high: the alert is active low and released between events
    initial begin
        platform_hot_input_n = 1'b1;
    end
    // changes land on the falling edge so the block samples a settled level
    task automatic alert_on();
        @(negedge mclk);
        platform_hot_input_n = 1'b0;
    endtask
    task automatic alert_off();
        @(negedge mclk);
        platform_hot_input_n = 1'b1;
    endtask
endmodule

//--- test_thermal_trip_logic.sv
`timescale 1ns/100ps
module test_thermal_trip_logic;
    logic mclk = 1'b0, rst = 1'b1, clk_en = 1'b1, high_freq_pll_lock = 1'b0;
    logic [39:0] sensor_reading = {5{8'hc8}};
    logic [4:0] sensor_group_mask = 5'h00, sensor_cat_trip;
    logic sensor_group_en = 1'b0, cat_trip_en = 1'b0, core_hot_trip = 1'b0;
    logic [2:0] sensor_select = 3'h0;
    logic [3:0] thresh_wr = 4'h0, trip_en = 4'h0;
    logic [7:0] thresh_wdata = 8'h00, below_tjmax_deg;
    logic [5:0] status_clr = 6'h00, trip_status;
    logic [11:0] action_map = 12'h000;
    logic [1:0] scheme_en = 2'h0, throttle_req;
    logic [31:0] trip_thresh;
    logic platform_hot_input_n, sensors_enabled, catastrophic_shutdown;
    logic hot_trip_report, core_hot_report;
    int err_count = 0, comparisons = 0;
    initial begin
        forever #2 mclk = ~mclk;
    end
    ttl_platform_model u_ttl_platform_model (.mclk(mclk),
        .platform_hot_input_n(platform_hot_input_n));
    ttl_thermal_trip u_ttl_thermal_trip (.mclk(mclk), .rst(rst), .clk_en(clk_en),
        .high_freq_pll_lock(high_freq_pll_lock), .sensor_reading(sensor_reading),
        .sensor_group_mask(sensor_group_mask), .sensor_group_en(sensor_group_en),
        .sensor_select(sensor_select), .cat_trip_en(cat_trip_en),
        .fuse_cat_limit(8'h64), .fuse_hot_thresh(8'h78), .thresh_wr(thresh_wr),
        .thresh_wdata(thresh_wdata), .trip_en(trip_en), .core_hot_trip(core_hot_trip),
        .platform_hot_input_n(platform_hot_input_n), .status_clr(status_clr),
        .action_map(action_map), .scheme_en(scheme_en), .sensors_enabled(sensors_enabled),
        .sensor_cat_trip(sensor_cat_trip), .catastrophic_shutdown(catastrophic_shutdown),
        .trip_thresh(trip_thresh), .trip_status(trip_status),
        .hot_trip_report(hot_trip_report), .core_hot_report(core_hot_report),
        .throttle_req(throttle_req), .below_tjmax_deg(below_tjmax_deg));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // inputs move only on the falling edge
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        rst = 1'b1;
        step(10);
        rst = 1'b0;
        chk("thresholds", trip_thresh, 32'h7800_0000);
        chk("shutdown", catastrophic_shutdown, 1'b0);
        $display("test reset done");
    endtask
    // hot sensor with no lock, then lock but compare disabled
    task automatic t_prelock();
        sensor_reading[15:8] = 8'h10;
        cat_trip_en = 1'b1;
        step(4);
        chk("prelock trips", {sensors_enabled, sensor_cat_trip}, 6'h00);
        cat_trip_en = 1'b0;
        high_freq_pll_lock = 1'b1;
        step(4);
        chk("disabled trips", {sensors_enabled, sensor_cat_trip}, 6'h20);
        sensor_reading[15:8] = 8'hc8;
        $display("test prelock done");
    endtask
    task automatic t_trip_points();
        thresh_wdata = 8'h96;
        thresh_wr = 4'h1;
        step(1);
        thresh_wr = 4'h0;
        chk("gen zero thresh", trip_thresh, 32'h7800_0096);
        trip_en = 4'h3;
        action_map = 12'h001;
        scheme_en = 2'h3;
        sensor_reading[7:0] = 8'h8c;
        step(3);
        chk("status", trip_status, 6'h01);
        chk("throttle", throttle_req, 2'h1);
        chk("degrees", below_tjmax_deg, 8'h0d);
        sensor_reading[7:0] = 8'hc8;
        step(3);
        chk("sticky", trip_status, 6'h01);
        status_clr = 6'h01;
        step(1);
        status_clr = 6'h00;
        step(2);
        chk("cleared", trip_status, 6'h00);
        trip_en = 4'h8;
        sensor_reading[7:0] = 8'h78;
        core_hot_trip = 1'b1;
        step(3);
        chk("reports", {hot_trip_report, core_hot_report}, 2'h3);
        $display("test trip points done");
    endtask
    task automatic t_platform();
        sensor_reading[7:0] = 8'hc8;
        core_hot_trip = 1'b0;
        action_map = 12'h000;
        scheme_en = 2'h2;
        status_clr = 6'h3f;
        step(1);
        status_clr = 6'h00;
        u_ttl_platform_model.alert_on();
        step(1);
        chk("scheme gate", throttle_req, 2'h2);
        u_ttl_platform_model.alert_off();
        step(1);
        chk("plat status", trip_status[5], 1'b1);
        $display("test platform done");
    endtask
    // masked-out hot sensor ignored, then included; direct select too
    task automatic t_grouping();
        trip_en = 4'h1;
        sensor_reading[31:24] = 8'ha0;
        sensor_reading[39:32] = 8'h80;
        sensor_group_en = 1'b1;
        sensor_group_mask = 5'h08;
        status_clr = 6'h3f;
        step(1);
        status_clr = 6'h00;
        step(2);
        chk("group masked", trip_status, 6'h00);
        chk("group degrees", below_tjmax_deg, 8'h21);
        sensor_group_mask = 5'h18;
        step(2);
        chk("group hottest", trip_status, 6'h01);
        chk("hottest degrees", below_tjmax_deg, 8'h01);
        sensor_group_en = 1'b0;
        sensor_select = 3'h4;
        status_clr = 6'h3f;
        step(1);
        status_clr = 6'h00;
        chk("set beats clear", trip_status, 6'h01);
        sensor_select = 3'h3;
        status_clr = 6'h3f;
        step(1);
        status_clr = 6'h00;
        step(1);
        chk("select cool", trip_status, 6'h00);
        sensor_select = 3'h0;
        sensor_group_mask = 5'h00;
        sensor_reading[39:24] = 16'hc8c8;
        trip_en = 4'h0;
        $display("test grouping done");
    endtask
    task automatic t_freeze();
        clk_en = 1'b0;
        core_hot_trip = 1'b1;
        step(3);
        chk("frozen", trip_status, 6'h00);
        clk_en = 1'b1;
        step(1);
        chk("thawed", trip_status, 6'h10);
        chk("core report", core_hot_report, 1'b1);
        core_hot_trip = 1'b0;
        status_clr = 6'h10;
        step(1);
        status_clr = 6'h00;
        $display("test freeze done");
    endtask
    task automatic t_catastrophic();
        cat_trip_en = 1'b1;
        sensor_reading[23:16] = 8'h64;
        step(1);
        chk("cat trip", sensor_cat_trip, 5'h04);
        chk("shutdown early", catastrophic_shutdown, 1'b0);
        step(1);
        chk("shutdown", catastrophic_shutdown, 1'b1);
        sensor_reading[23:16] = 8'hc8;
        cat_trip_en = 1'b0;
        status_clr = 6'h3f;
        step(3);
        status_clr = 6'h00;
        chk("latched", {catastrophic_shutdown, sensor_cat_trip}, 6'h24);
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        chk("power cycle", {catastrophic_shutdown, sensor_cat_trip}, 6'h00);
        chk("thresholds again", trip_thresh, 32'h7800_0000);
        $display("test catastrophic done");
    endtask
    initial begin
        t_reset();
        t_prelock();
        t_trip_points();
        t_platform();
        t_grouping();
        t_freeze();
        t_catastrophic();
        results();
    end
endmodule
